/* csq_pkg.sv */
package csq_pkg;

    // clock and time bases
    localparam longint CSQ_CLK_HZ = 200_000_000;
    localparam int CSQ_TW = 42;
    localparam longint CSQ_START_DLY_MS = 27;
    localparam longint CSQ_TRK_DGL_MS = 27;
    localparam longint CSQ_TOPQ_MS = 27;
    localparam longint CSQ_PRECHG_MIN = 45;
    localparam longint CSQ_FAST_STEP_MIN = 60;
    localparam longint CSQ_TOPOFF_STEP_MIN = 45;
    localparam logic [CSQ_TW-1:0] CSQ_START_DLY_CYC = CSQ_TW'(CSQ_START_DLY_MS * CSQ_CLK_HZ / 1000);
    localparam logic [CSQ_TW-1:0] CSQ_TRK_DGL_CYC = CSQ_TW'(CSQ_TRK_DGL_MS * CSQ_CLK_HZ / 1000);
    localparam logic [CSQ_TW-1:0] CSQ_TOPQ_CYC = CSQ_TW'(CSQ_TOPQ_MS * CSQ_CLK_HZ / 1000);
    localparam logic [CSQ_TW-1:0] CSQ_PRECHG_CYC = CSQ_TW'(CSQ_PRECHG_MIN * 60 * CSQ_CLK_HZ);
    localparam logic [CSQ_TW-1:0] CSQ_FAST_STEP_CYC = CSQ_TW'(CSQ_FAST_STEP_MIN * 60 * CSQ_CLK_HZ);
    localparam logic [CSQ_TW-1:0] CSQ_TOPOFF_STEP_CYC =
        CSQ_TW'(CSQ_TOPOFF_STEP_MIN * 60 * CSQ_CLK_HZ);

    // register offsets
    localparam logic [7:0] CSQ_CTRL_OFS = 8'h00;
    localparam logic [7:0] CSQ_ICHG_OFS = 8'h04;
    localparam logic [7:0] CSQ_VREG_OFS = 8'h08;
    localparam logic [7:0] CSQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] CSQ_INT_OFS = 8'h10;

    // field positions
    localparam int CSQ_EN_POS = 0;
    localparam int CSQ_SUSP_POS = 1;
    localparam int CSQ_ASTOP_POS = 2;
    localparam int CSQ_PRE_POS = 0;
    localparam int CSQ_FAST_POS = 4;
    localparam int CSQ_ILIM_POS = 12;
    localparam int CSQ_TOPI_POS = 20;
    localparam int CSQ_VREG_POS = 0;
    localparam int CSQ_FTMR_POS = 4;
    localparam int CSQ_TTMR_POS = 8;
    localparam int CSQ_STATE_POS = 0;
    localparam int CSQ_FLAG_POS = 8;

    // currents in mA, voltage in mV
    localparam logic [11:0] CSQ_TRICKLE_MA = 12'h05a;
    localparam logic [11:0] CSQ_PRE_BASE_MA = 12'h096;
    localparam logic [11:0] CSQ_PRE_STEP_MA = 12'h064;
    localparam logic [11:0] CSQ_FAST_BASE_MA = 12'h064;
    localparam logic [11:0] CSQ_FAST_STEP_MA = 12'h064;
    localparam logic [4:0] CSQ_FAST_MAX_CODE = 5'h13;
    localparam logic [11:0] CSQ_TOPI_BASE_MA = 12'h064;
    localparam logic [11:0] CSQ_TOPI_STEP_MA = 12'h032;
    localparam logic [4:0] CSQ_TOPI_MAX_CODE = 5'h0b;
    localparam logic [12:0] CSQ_VREG_BASE_MV = 13'h1004;
    localparam logic [12:0] CSQ_VREG_STEP_MV = 13'h0019;

    // interrupt bits
    localparam int CSQ_IRQ_TOPOFF = 0;
    localparam int CSQ_IRQ_DONE = 1;
    localparam int CSQ_IRQ_PREFLT = 2;
    localparam int CSQ_IRQ_FASTFLT = 3;

    typedef enum logic [3:0] {
        CSQ_SUSPEND, CSQ_START, CSQ_TRICKLE, CSQ_PRE, CSQ_FAST,
        CSQ_FULL, CSQ_TOPOFF, CSQ_DONE, CSQ_FAULT
    } csq_chg_e;

    typedef struct packed {
        logic input_margin_ok;
        logic input_uvlo_ok;
        logic input_ovp;
        logic die_hot;
        logic battery_absent_pin;
        logic hw_charge_disable_pin;
        logic batt_above_trickle;
        logic batt_above_sysmin;
        logic batt_at_reg;
        logic ichg_at_topoff;
        logic batt_above_connect;
        logic sysrail_low;
        logic sysrail_started;
    } csq_cmp_s;

    typedef struct packed {
        logic sw_charge_enable_bit;
        logic suspend_request_bit;
        logic stop_after_topoff;
        logic [1:0] pre_code;
        logic [4:0] fast_code;
        logic [4:0] ilim_code;
        logic [3:0] topi_code;
        logic [3:0] vreg_code;
        logic [1:0] fast_tmr_sel;
        logic [1:0] topoff_tmr_sel;
    } csq_cfg_s;

    localparam csq_cfg_s CSQ_CFG_RST = '{
        sw_charge_enable_bit: 1'b1, suspend_request_bit: 1'b0,
        stop_after_topoff: 1'b1, pre_code: 2'h0, fast_code: 5'h04,
        ilim_code: 5'h04, topi_code: 4'h0, vreg_code: 4'h0,
        fast_tmr_sel: 2'h0, topoff_tmr_sel: 2'h0};

    typedef struct packed {
        logic buck_on;
        logic battery_path_switch;
        logic logic_regulator_on;
        logic [11:0] charge_current_ma;
        logic [12:0] batt_reg_mv;
    } csq_drv_s;

    function automatic logic [11:0] csq_ma(input logic [11:0] base, input logic [11:0] step,
                                           input logic [4:0] code);
        csq_ma = 12'(base + step * code);
    endfunction : csq_ma

endpackage : csq_pkg

/* csq_sequencer.sv */
`timescale 1ns/1ps

module csq_sequencer
    import csq_pkg::*;
#(
    parameter logic [CSQ_TW-1:0] START_DLY_CYC = CSQ_START_DLY_CYC,
    parameter logic [CSQ_TW-1:0] TRK_DGL_CYC = CSQ_TRK_DGL_CYC,
    parameter logic [CSQ_TW-1:0] TOPQ_CYC = CSQ_TOPQ_CYC,
    parameter logic [CSQ_TW-1:0] PRECHG_CYC = CSQ_PRECHG_CYC,
    parameter logic [CSQ_TW-1:0] FAST_STEP_CYC = CSQ_FAST_STEP_CYC,
    parameter logic [CSQ_TW-1:0] TOPOFF_STEP_CYC = CSQ_TOPOFF_STEP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // comparators and pins
    input wire csq_cmp_s cmp_in,
    // power stage controls
    output csq_drv_s drv,
    // open-drain interrupt pin
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe,
    output logic interrupt_out_n
);

    typedef struct packed {
        csq_cmp_s s1;
        csq_cmp_s s2;
        csq_chg_e st;
        logic [CSQ_TW-1:0] tmr;
        logic [CSQ_TW-1:0] dgl;
        csq_cfg_s cfg;
        logic [3:0] irq;
        csq_drv_s drv;
        logic irq_o;
        logic irq_oe;
        logic irq_n;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } csq_state_s;

    localparam csq_state_s CSQ_ST_RST = '{
        s1: '0, s2: '0, st: CSQ_SUSPEND, tmr: '0, dgl: '0,
        cfg: CSQ_CFG_RST, irq: 4'h0, drv: '0, irq_o: 1'b0,
        irq_oe: 1'b0, irq_n: 1'b1, pready: 1'b0, prdata: 32'h0,
        pslverr: 1'b0};

    csq_state_s r;
    csq_state_s next_r;
    csq_cmp_s c;
    logic valid_in;
    logic qual_ok;
    logic acc;
    logic wr;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic [11:0] fast_ma;
    logic [11:0] ilim_ma;
    logic [11:0] topi_ma;
    logic [CSQ_TW-1:0] fast_lim;
    logic [CSQ_TW-1:0] top_lim;
    logic fast_tmr_en;

    function automatic logic [4:0] clamp_code(input logic [4:0] code, input logic [4:0] top);
        clamp_code = (code > top) ? top : code;
    endfunction : clamp_code

    function automatic logic [31:0] ctrl_word(input csq_cfg_s f);
        ctrl_word = 32'h0;
        ctrl_word[CSQ_EN_POS] = f.sw_charge_enable_bit;
        ctrl_word[CSQ_SUSP_POS] = f.suspend_request_bit;
        ctrl_word[CSQ_ASTOP_POS] = f.stop_after_topoff;
    endfunction : ctrl_word

    function automatic logic [31:0] ichg_word(input csq_cfg_s f);
        ichg_word = 32'h0;
        ichg_word[CSQ_PRE_POS +: 2] = f.pre_code;
        ichg_word[CSQ_FAST_POS +: 5] = f.fast_code;
        ichg_word[CSQ_ILIM_POS +: 5] = f.ilim_code;
        ichg_word[CSQ_TOPI_POS +: 4] = f.topi_code;
    endfunction : ichg_word

    function automatic logic [31:0] vreg_word(input csq_cfg_s f);
        vreg_word = 32'h0;
        vreg_word[CSQ_VREG_POS +: 4] = f.vreg_code;
        vreg_word[CSQ_FTMR_POS +: 2] = f.fast_tmr_sel;
        vreg_word[CSQ_TTMR_POS +: 2] = f.topoff_tmr_sel;
    endfunction : vreg_word

    always_comb begin
        next_r = r;
        irq_set = 4'h0;
        irq_clr = 4'h0;
        next_r.s1 = cmp_in;
        next_r.s2 = r.s1;
        c = r.s2;

        valid_in = c.input_margin_ok & c.input_uvlo_ok & ~c.input_ovp;
        qual_ok = r.cfg.sw_charge_enable_bit & ~r.cfg.suspend_request_bit &
                  ~c.hw_charge_disable_pin & valid_in &
                  ~c.battery_absent_pin &
                  ~c.die_hot;

        fast_ma = csq_ma(CSQ_FAST_BASE_MA, CSQ_FAST_STEP_MA,
                         clamp_code(r.cfg.fast_code, CSQ_FAST_MAX_CODE));
        ilim_ma = csq_ma(CSQ_FAST_BASE_MA, CSQ_FAST_STEP_MA,
                         clamp_code(r.cfg.ilim_code, CSQ_FAST_MAX_CODE));
        topi_ma = csq_ma(CSQ_TOPI_BASE_MA, CSQ_TOPI_STEP_MA,
                         clamp_code({1'b0, r.cfg.topi_code}, CSQ_TOPI_MAX_CODE));
        // disabled by default or lowest limit
        fast_tmr_en = (r.cfg.fast_tmr_sel != 2'h0) && (r.cfg.ilim_code != 5'h00);
        fast_lim = CSQ_TW'(FAST_STEP_CYC * r.cfg.fast_tmr_sel);
        top_lim = CSQ_TW'(TOPOFF_STEP_CYC * (3'(r.cfg.topoff_tmr_sel) + 3'h1));

        // apb: one wait state, answer registered
        acc = psel & penable;
        wr = acc & r.pready & pwrite;
        next_r.pready = acc & ~r.pready;
        if (acc && !r.pready) begin
            next_r.pslverr = 1'b0;
            case (paddr)
                CSQ_CTRL_OFS: next_r.prdata = ctrl_word(r.cfg);
                CSQ_ICHG_OFS: next_r.prdata = ichg_word(r.cfg);
                CSQ_VREG_OFS: next_r.prdata = vreg_word(r.cfg);
                CSQ_STAT_OFS: begin
                    next_r.prdata = 32'h0;
                    next_r.prdata[CSQ_STATE_POS +: 4] = r.st;
                    next_r.prdata[CSQ_FLAG_POS +: 13] = c;
                end
                CSQ_INT_OFS: next_r.prdata = {28'h0, r.irq};
                default: begin
                    next_r.prdata = 32'h0;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        if (wr) begin
            case (paddr)
                CSQ_CTRL_OFS: begin
                    next_r.cfg.sw_charge_enable_bit = pwdata[CSQ_EN_POS];
                    next_r.cfg.suspend_request_bit = pwdata[CSQ_SUSP_POS];
                    next_r.cfg.stop_after_topoff = pwdata[CSQ_ASTOP_POS];
                end
                CSQ_ICHG_OFS: begin
                    next_r.cfg.pre_code = pwdata[CSQ_PRE_POS +: 2];
                    next_r.cfg.fast_code = pwdata[CSQ_FAST_POS +: 5];
                    next_r.cfg.ilim_code = pwdata[CSQ_ILIM_POS +: 5];
                    next_r.cfg.topi_code = pwdata[CSQ_TOPI_POS +: 4];
                end
                CSQ_VREG_OFS: begin
                    next_r.cfg.vreg_code = pwdata[CSQ_VREG_POS +: 4];
                    next_r.cfg.fast_tmr_sel = pwdata[CSQ_FTMR_POS +: 2];
                    next_r.cfg.topoff_tmr_sel = pwdata[CSQ_TTMR_POS +: 2];
                end
                CSQ_INT_OFS: irq_clr = pwdata[3:0];
                default: ;
            endcase
        end
        if (c.sysrail_low) begin
            next_r.cfg = CSQ_CFG_RST;
        end

        next_r.drv.charge_current_ma = 12'h000;
        next_r.tmr = r.tmr + CSQ_TW'(1);
        next_r.dgl = 0;
        case (r.st)
            CSQ_SUSPEND: begin
                next_r.tmr = 0;
                if (qual_ok) begin
                    next_r.st = CSQ_START;
                end
            end
            CSQ_START: begin
                if (c.sysrail_started) begin
                    next_r.dgl = r.dgl + CSQ_TW'(1);
                end
                if (c.sysrail_started && r.dgl >= START_DLY_CYC - CSQ_TW'(1)) begin
                    next_r.st = CSQ_TRICKLE;
                    next_r.dgl = 0;
                end
            end
            CSQ_TRICKLE: begin
                next_r.drv.charge_current_ma = CSQ_TRICKLE_MA;
                next_r.tmr = 0;
                if (c.batt_above_trickle) begin
                    next_r.dgl = r.dgl + CSQ_TW'(1);
                    if (r.dgl >= TRK_DGL_CYC - CSQ_TW'(1)) begin
                        next_r.st = CSQ_PRE;
                        next_r.dgl = 0;
                    end
                end
            end
            CSQ_PRE: begin
                next_r.drv.charge_current_ma =
                    csq_ma(CSQ_PRE_BASE_MA, CSQ_PRE_STEP_MA, {3'h0, r.cfg.pre_code});
                if (c.batt_above_sysmin) begin
                    next_r.st = CSQ_FAST;
                    next_r.tmr = 0;
                end else if (r.tmr >= PRECHG_CYC - CSQ_TW'(1)) begin
                    next_r.st = CSQ_FAULT;
                    irq_set[CSQ_IRQ_PREFLT] = 1'b1;
                end
            end
            CSQ_FAST: begin
                next_r.drv.charge_current_ma = (fast_ma > ilim_ma) ? ilim_ma : fast_ma;
                if (!fast_tmr_en) begin
                    next_r.tmr = 0;
                end
                if (c.batt_at_reg) begin
                    next_r.st = CSQ_FULL;
                    next_r.tmr = 0;
                // fast timer expiry is a fault
                end else if (fast_tmr_en && r.tmr >= fast_lim - CSQ_TW'(1)) begin
                    next_r.st = CSQ_FAULT;
                    irq_set[CSQ_IRQ_FASTFLT] = 1'b1;
                end
            end
            CSQ_FULL: begin
                next_r.drv.charge_current_ma = topi_ma;
                next_r.tmr = 0;
                if (c.ichg_at_topoff) begin
                    next_r.dgl = r.dgl + CSQ_TW'(1);
                    if (r.dgl >= TOPQ_CYC - CSQ_TW'(1)) begin
                        next_r.st = CSQ_TOPOFF;
                        next_r.dgl = 0;
                        irq_set[CSQ_IRQ_TOPOFF] = 1'b1;
                    end
                end
            end
            CSQ_TOPOFF: begin
                next_r.drv.charge_current_ma = topi_ma;
                if (r.tmr >= top_lim - CSQ_TW'(1)) begin
                    next_r.st = CSQ_DONE;
                    irq_set[CSQ_IRQ_DONE] = 1'b1;
                end
            end
            CSQ_DONE: begin
                next_r.tmr = 0;
                next_r.drv.charge_current_ma =
                    r.cfg.stop_after_topoff ? 12'h000 : topi_ma;
            end
            CSQ_FAULT: begin
                // held until any qualification condition drops
                next_r.tmr = 0;
            end
            default: begin
                next_r.st = CSQ_SUSPEND;
            end
        endcase
        if (!qual_ok) begin
            next_r.st = CSQ_SUSPEND;
            next_r.tmr = 0;
            next_r.dgl = 0;
            next_r.drv.charge_current_ma = 12'h000;
        end

        next_r.drv.batt_reg_mv =
            13'(CSQ_VREG_BASE_MV + CSQ_VREG_STEP_MV * r.cfg.vreg_code);
        next_r.drv.buck_on = c.input_uvlo_ok & ~c.input_ovp;
        next_r.drv.logic_regulator_on = valid_in;
        // battery feeds the rail, no input
        if (!valid_in && c.batt_above_connect) begin
            next_r.drv.battery_path_switch = 1'b1;
        end else if (c.battery_absent_pin) begin
            next_r.drv.battery_path_switch = 1'b0;
        end else begin
            next_r.drv.battery_path_switch = valid_in;
        end

        // set beats a same-cycle clear
        next_r.irq = (r.irq & ~irq_clr) | irq_set;
        next_r.irq_oe = |next_r.irq;
        next_r.irq_n = ~|next_r.irq;
        next_r.irq_o = 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= CSQ_ST_RST;
        end else begin
            r <= next_r;
        end
    end

    assign pready = r.pready;
    assign prdata = r.prdata;
    assign pslverr = r.pslverr;
    assign drv = r.drv;
    assign interrupt_out_n_o = r.irq_o;
    assign interrupt_out_n_oe = r.irq_oe;
    assign interrupt_out_n = r.irq_n;

endmodule : csq_sequencer

/* csq_cell_model.sv */
`timescale 1ns/1ps
module csq_cell_model
    import csq_pkg::*;
(
    // bench controls
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sup,
    input wire logic mrg,
    input wire logic low,
    input wire logic ld,
    input wire logic [3:0] flt,
    input wire logic [3:0] sh,
    input wire logic [12:0] ld_mv,
    // device side
    input wire csq_drv_s drv,
    output csq_cmp_s cmp
);
    logic [12:0] mv;
    logic at_reg;
    // cell only gains charge through a closed path with the buck running
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) mv <= 13'h07d0;
        else if (ld) mv <= ld_mv;
        else if (drv.buck_on && drv.battery_path_switch && !at_reg)
            mv <= mv + 13'(drv.charge_current_ma >> sh);
    end
    // current tapers once the cell sits at the regulation level
    assign at_reg = mv >= drv.batt_reg_mv;
    // margin can fail on its own; the rail counts as started unless it sags
    assign cmp = '{sup & ~mrg, sup, flt[3], flt[2], flt[1], flt[0], mv > 13'h09c4,
                   mv > 13'h0e10, at_reg, at_reg, mv > 13'h0960, low, ~low};
endmodule : csq_cell_model

/* csq_seq_checker.sv */
`timescale 1ns/1ps
module csq_seq_checker
    import csq_pkg::*;
(
    // clock, reset and apb
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire csq_cmp_s cmp_in,
    input wire csq_drv_s drv,
    input wire logic interrupt_out_n_o,
    input wire logic interrupt_out_n_oe,
    input wire logic interrupt_out_n
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    property p_rdy_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
    property p_slverr;
        pready && paddr > 8'h10 |-> pslverr;
    endproperty
    a_slverr: assert property (p_slverr) else $error("no slave error");
    property p_dis;
        cmp_in.hw_charge_disable_pin [*6] |-> drv.charge_current_ma == 12'h000;
    endproperty
    a_dis: assert property (p_dis) else $error("charging while disabled");
    property p_abs;
        (cmp_in.battery_absent_pin && cmp_in.input_margin_ok) [*6] |-> !drv.battery_path_switch;
    endproperty
    a_abs: assert property (p_abs) else $error("path closed, no cell");
    property p_hot;
        cmp_in.die_hot [*6] |-> drv.charge_current_ma == 12'h000;
    endproperty
    a_hot: assert property (p_hot) else $error("charging while hot");
    property p_ovp;
        cmp_in.input_ovp [*4] |-> !drv.buck_on;
    endproperty
    a_ovp: assert property (p_ovp) else $error("buck on in overvoltage");
    property p_nobus;
        (!cmp_in.input_margin_ok && !cmp_in.input_uvlo_ok && cmp_in.batt_above_connect) [*5]
            |-> drv.battery_path_switch && !drv.logic_regulator_on;
    endproperty
    a_nobus: assert property (p_nobus) else $error("path open, no input");
    property p_pin;
        interrupt_out_n == !interrupt_out_n_oe && !interrupt_out_n_o;
    endproperty
    a_pin: assert property (p_pin) else $error("interrupt pin mismatch");
    c_irq: cover property ($rose(interrupt_out_n_oe));
    c_err: cover property (pready && pslverr);
    c_ovp: cover property ($fell(drv.buck_on) && cmp_in.input_ovp);
endmodule : csq_seq_checker

/* test_charge_profile_sequencer.sv */
`timescale 1ns/1ps
module test_charge_profile_sequencer;
    import csq_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, io_o, io_oe, irq_n;
    logic [31:0] prdata;
    csq_cmp_s cmp;
    csq_drv_s drv;
    logic sup = 1'b0;
    logic mrg = 1'b0;
    logic low = 1'b0;
    logic ld = 1'b0;
    logic [3:0] flt = 4'h0;
    logic [3:0] sh = 4'h2;
    logic [12:0] ld_mv = 13'h07d0;
    int error_cnt = 0;
    int checks = 0;
    always #2.5 clk = ~clk;
    csq_sequencer #(.START_DLY_CYC(42'h8), .TRK_DGL_CYC(42'h8), .TOPQ_CYC(42'h8),
        .PRECHG_CYC(42'h40), .FAST_STEP_CYC(42'h40), .TOPOFF_STEP_CYC(42'h40)) u_dut (
        .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .cmp_in(cmp), .drv, .interrupt_out_n_o(io_o),
        .interrupt_out_n_oe(io_oe), .interrupt_out_n(irq_n));
    csq_cell_model u_cell (.clk, .sys_rst, .sup, .mrg, .low, .ld, .flt, .sh, .ld_mv, .drv,
        .cmp);
    task automatic end_sim;
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            end_sim();
        end
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q & m, x);
    endtask : rd
    task automatic ldv(input logic [12:0] v);
        ld_mv <= v;
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
    endtask : ldv
    // waits on the pin going low, or on the charge current reaching e
    task automatic wt(input logic pin, input logic [11:0] e);
        int n = 0;
        while ((pin ? irq_n !== 1'b0 : drv.charge_current_ma !== e) && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (!pin) chk(32'(drv.charge_current_ma), 32'(e));
        if (n >= 3000) begin
            error_cnt++;
            end_sim();
        end
    endtask : wt
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        ldv(13'h0bb8);
        rd(CSQ_CTRL_OFS, 32'hffffffff, 32'h5);
        chk({30'h0, drv.battery_path_switch, drv.logic_regulator_on}, 32'h2);
        rd(CSQ_ICHG_OFS, 32'hffffffff, 32'h4040);
        rd(CSQ_VREG_OFS, 32'hffffffff, 32'h0);
        apb(1'b0, 8'h14, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        wr(CSQ_STAT_OFS, 32'h7);
        rd(CSQ_STAT_OFS, 32'hf, 32'h0);
        wr(CSQ_ICHG_OFS, 32'h1);
        low <= 1'b1;
        repeat (4) @(posedge clk);
        low <= 1'b0;
        rd(CSQ_ICHG_OFS, 32'hffffffff, 32'h4040);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_prof;
        ldv(13'h07d0);
        wr(CSQ_ICHG_OFS, 32'h00b07132);
        wr(CSQ_VREG_OFS, 32'hf);
        sup <= 1'b1;
        wt(1'b0, CSQ_TRICKLE_MA);
        wt(1'b0, 12'h15e);
        wt(1'b0, 12'h320);
        chk(32'(drv.batt_reg_mv), 32'h117b);
        wt(1'b0, 12'h28a);
        wt(1'b1, 12'h0);
        rd(CSQ_INT_OFS, 32'hffffffff, 32'h1);
        wr(CSQ_INT_OFS, 32'h1);
        wt(1'b0, 12'h0);
        rd(CSQ_INT_OFS, 32'hffffffff, 32'h2);
        rd(CSQ_STAT_OFS, 32'hf, 32'h7);
        wr(CSQ_CTRL_OFS, 32'h4);
        wr(CSQ_INT_OFS, 32'hf);
        rd(CSQ_INT_OFS, 32'hffffffff, 32'h0);
        chk({31'h0, irq_n}, 32'h1);
        $display("t_prof done");
    endtask : t_prof
    task automatic t_qual;
        sh <= 4'h6;
        ldv(13'h07d0);
        wr(CSQ_CTRL_OFS, 32'h5);
        wt(1'b0, CSQ_TRICKLE_MA);
        for (int i = 0; i < 5; i++) begin
            if (i < 4) flt <= 4'(1 << i);
            else wr(CSQ_CTRL_OFS, 32'h7);
            wt(1'b0, 12'h0);
            if (i < 4) flt <= 4'h0;
            else wr(CSQ_CTRL_OFS, 32'h5);
            wt(1'b0, CSQ_TRICKLE_MA);
        end
        // margin lost alone suspends, converter stays up
        mrg <= 1'b1;
        wt(1'b0, 12'h0);
        chk({31'h0, drv.buck_on}, 32'h1);
        mrg <= 1'b0;
        wt(1'b0, CSQ_TRICKLE_MA);
        sup <= 1'b0;
        repeat (4) @(posedge clk);
        chk({31'h0, drv.buck_on}, 32'h0);
        sup <= 1'b1;
        wt(1'b0, CSQ_TRICKLE_MA);
        // rail not started holds the sequencer in start
        wr(CSQ_CTRL_OFS, 32'h7);
        low <= 1'b1;
        repeat (20) @(posedge clk);
        chk(32'(drv.charge_current_ma), 32'h0);
        rd(CSQ_STAT_OFS, 32'hf, 32'h1);
        low <= 1'b0;
        wt(1'b0, CSQ_TRICKLE_MA);
        $display("t_qual done");
    endtask : t_qual
    task automatic t_flt;
        wr(CSQ_CTRL_OFS, 32'h4);
        ldv(13'h07d0);
        wr(CSQ_CTRL_OFS, 32'h5);
        wt(1'b1, 12'h0);
        rd(CSQ_STAT_OFS, 32'hf, 32'h8);
        rd(CSQ_INT_OFS, 32'hffffffff, 32'h4);
        // a fault only clears once qualification drops, here by dropping enable
        wr(CSQ_CTRL_OFS, 32'h4);
        wr(CSQ_INT_OFS, 32'hf);
        wr(CSQ_VREG_OFS, 32'h1f);
        wr(CSQ_ICHG_OFS, 32'h00b04132);
        ldv(13'h0e06);
        wr(CSQ_CTRL_OFS, 32'h5);
        wt(1'b1, 12'h0);
        rd(CSQ_INT_OFS, 32'hffffffff, 32'h8);
        wr(CSQ_CTRL_OFS, 32'h4);
        wr(CSQ_INT_OFS, 32'hf);
        wr(CSQ_ICHG_OFS, 32'h00b00132);
        ldv(13'h0e06);
        wr(CSQ_CTRL_OFS, 32'h5);
        wt(1'b0, 12'h064);
        wt(1'b1, 12'h0);
        rd(CSQ_INT_OFS, 32'hffffffff, 32'h1);
        $display("t_flt done");
    endtask : t_flt
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_prof();
        t_qual();
        t_flt();
        end_sim();
    end
endmodule : test_charge_profile_sequencer
bind csq_sequencer csq_seq_checker u_chk (.clk, .sys_rst, .psel, .penable, .paddr, .pready,
    .pslverr, .cmp_in, .drv, .interrupt_out_n_o, .interrupt_out_n_oe, .interrupt_out_n);
